//--- src/brc_ctrl.sv
// brown-out reset mode control, fast-start and regulator sleep power mode registers
`timescale 1ns/1ns
`include "brc_params.svh"

module brc_ctrl #(
    parameter int SETTLE_CYCLES = `BRC_SETTLE_CYCLES
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    // plain register port
    input  wire logic [`BRC_ADDR_W-1:0] i_addr,
    input  wire brc_pkg::brc_byte_t    i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output brc_pkg::brc_byte_t         o_rdata,
    // non-volatile configuration field and core sleep state
    input  wire brc_pkg::brc_mode_t    i_brownout_mode_cfg,
    input  wire logic                  i_sleep,
    // controls to the analog circuits
    output logic                       o_brownout_reset_en,
    output logic                       o_bandgap_force_on,
    output logic                       o_regulator_sleep_power_mode,
    output logic                       o_regulator_low_power,
    output logic                       o_brownout_circuit_ready
);
    import brc_pkg::*;

    // synchroniser for the configuration field
    brc_mode_t mode_meta_ff;
    brc_mode_t mode_ff;

    // software-visible state
    logic      sw_brownout_enable_ff;
    logic      brownout_fast_start_ff;
    logic      regulator_sleep_power_mode_ff;
    brc_byte_t rdata_ff;

    // decoded accesses
    logic      wr_bor;
    logic      wr_vreg;
    logic      rd_bor;
    logic      rd_vreg;

    // derived controls
    logic      bor_en;
    logic      fast_start_live;
    logic      ready;

    brc_byte_t bor_view;
    brc_byte_t vreg_view;

    // the configuration field comes from non-volatile storage outside this clock;
    // reset to always-on so protection never lapses while the field is fetched
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_meta_ff <= `BRC_MODE_SYNC_RST;
            mode_ff      <= `BRC_MODE_SYNC_RST;
        end else begin
            mode_meta_ff <= i_brownout_mode_cfg;
            mode_ff      <= mode_meta_ff;
        end
    end

    // address decode; unmapped writes are dropped
    always_comb begin
        wr_bor  = 1'b0;
        wr_vreg = 1'b0;
        rd_bor  = 1'b0;
        rd_vreg = 1'b0;
        if (i_addr == `BRC_BOR_CTRL_ADDR) begin
            wr_bor = i_wr;
            rd_bor = i_rd;
        end else if (i_addr == `BRC_VREG_CTRL_ADDR) begin
            wr_vreg = i_wr;
            rd_vreg = i_rd;
        end
    end

    // software brown-out enable: stored in every mode, only acts in mode 01
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sw_brownout_enable_ff <= `BRC_SW_EN_RST;
        end else if (wr_bor) begin
            sw_brownout_enable_ff <= i_wdata[`BRC_SW_EN_BIT];
        end
    end

    // fast-start bit: stored in every mode, only acts in modes 10 and 01
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            brownout_fast_start_ff <= `BRC_FAST_START_RST;
        end else if (wr_bor) begin
            brownout_fast_start_ff <= i_wdata[`BRC_FAST_START_BIT];
        end
    end

    // regulator power mode; the reserved bit is not stored, so a careless
    // write of 0 there cannot disturb the regulator
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            regulator_sleep_power_mode_ff <= `BRC_VREG_PM_RST;
        end else if (wr_vreg) begin
            regulator_sleep_power_mode_ff <= i_wdata[`BRC_VREG_PM_BIT];
        end
    end

    // effective brown-out enable from mode, software bit and sleep
    always_comb begin
        case (mode_ff)
            `BRC_MODE_ALWAYS_ON:    bor_en = 1'b1;
            `BRC_MODE_OFF_IN_SLEEP: bor_en = !i_sleep;
            `BRC_MODE_SOFTWARE:     bor_en = sw_brownout_enable_ff;
            default:                bor_en = 1'b0;
        endcase
    end

    // band gap is held on only where fast start has meaning
    always_comb begin
        fast_start_live = (mode_ff == `BRC_MODE_OFF_IN_SLEEP) ||
                          (mode_ff == `BRC_MODE_SOFTWARE);
    end

    assign o_brownout_reset_en          = bor_en;
    assign o_bandgap_force_on           = fast_start_live && brownout_fast_start_ff;
    assign o_regulator_sleep_power_mode = regulator_sleep_power_mode_ff;
    // the low-power state only applies while the core sleeps; costs slower wake-up
    assign o_regulator_low_power        = regulator_sleep_power_mode_ff && i_sleep;

    // ready status: the analog settling time is unknown, so it is a count
    brc_settle #(
        .SETTLE_CYCLES (SETTLE_CYCLES)
    ) u_settle (
        .i_clk    (i_clk),
        .i_rst    (i_rst),
        .i_enable (bor_en),
        .o_ready  (ready)
    );

    assign o_brownout_circuit_ready = ready;

    // read views; unused positions are tied low, the reserved regulator_control bit reads high
    always_comb begin
        bor_view                        = `BRC_RDATA_IDLE;
        bor_view[`BRC_SW_EN_BIT]        = sw_brownout_enable_ff;
        bor_view[`BRC_FAST_START_BIT]   = brownout_fast_start_ff;
        bor_view[`BRC_READY_BIT]        = ready;
        vreg_view                       = `BRC_RDATA_IDLE;
        vreg_view[`BRC_VREG_PM_BIT]     = regulator_sleep_power_mode_ff;
        vreg_view[`BRC_VREG_RSVD_BIT]   = `BRC_VREG_RSVD_VAL;
    end

    // read data stand only in the cycle after the strobe; zero otherwise
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_ff <= `BRC_RDATA_IDLE;
        end else if (rd_bor) begin
            rdata_ff <= bor_view;
        end else if (rd_vreg) begin
            rdata_ff <= vreg_view;
        end else begin
            rdata_ff <= `BRC_RDATA_IDLE;
        end
    end

    assign o_rdata = rdata_ff;

    // checks on the block's own behaviour
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    AST_MODE_ALWAYS_ON: assert property (
        mode_ff == `BRC_MODE_ALWAYS_ON |-> o_brownout_reset_en
    ) else $error("brown-out reset off in always-on mode");

    AST_MODE_ALWAYS_OFF: assert property (
        mode_ff == `BRC_MODE_ALWAYS_OFF |-> !o_brownout_reset_en && !o_bandgap_force_on
    ) else $error("brown-out reset or band gap on in always-off mode");

    AST_MODE_SLEEP_OFF: assert property (
        mode_ff == `BRC_MODE_OFF_IN_SLEEP |-> o_brownout_reset_en == !i_sleep
    ) else $error("sleep-off mode does not follow sleep");

    AST_SW_CONTROL: assert property (
        (mode_ff == `BRC_MODE_SOFTWARE) && wr_bor
        |=> (mode_ff != `BRC_MODE_SOFTWARE) || (o_brownout_reset_en == $past(i_wdata[`BRC_SW_EN_BIT]))
    ) else $error("software enable write not applied in software mode");

    AST_SW_NO_EFFECT: assert property (
        (mode_ff != `BRC_MODE_SOFTWARE) && $stable(mode_ff) && $stable(i_sleep)
        && $changed(sw_brownout_enable_ff) |-> $stable(o_brownout_reset_en)
    ) else $error("software enable acted outside software mode");

    AST_FAST_START_LIVE: assert property (
        (mode_ff == `BRC_MODE_OFF_IN_SLEEP || mode_ff == `BRC_MODE_SOFTWARE)
        |-> o_bandgap_force_on == brownout_fast_start_ff
    ) else $error("band gap force does not follow fast start");

    AST_FAST_START_DEAD: assert property (
        mode_ff == `BRC_MODE_ALWAYS_ON |-> !o_bandgap_force_on
    ) else $error("fast start acted in always-on mode");

    AST_READY_READBACK: assert property (
        rd_bor |=> o_rdata[`BRC_READY_BIT] == $past(o_brownout_circuit_ready)
                   && o_rdata[`BRC_SW_EN_BIT] == $past(sw_brownout_enable_ff)
    ) else $error("brownout_control read does not show ready and enable");

    AST_UNUSED_ZERO: assert property (
        rd_bor |=> o_rdata[5:1] == 5'h0_0
    ) else $error("unused brownout_control bits read nonzero");

    AST_VREG_READBACK: assert property (
        rd_vreg |=> o_rdata[`BRC_VREG_RSVD_BIT] == 1'b1 && o_rdata[7:2] == 6'h0_0
                    && o_rdata[`BRC_VREG_PM_BIT] == $past(regulator_sleep_power_mode_ff)
    ) else $error("regulator_control read value wrong");

    AST_VREG_WRITE: assert property (
        wr_vreg ##1 i_sleep |-> o_regulator_low_power == $past(i_wdata[`BRC_VREG_PM_BIT])
    ) else $error("regulator low-power state does not follow written bit");

    AST_READY_DROP: assert property (
        !o_brownout_reset_en |=> !o_brownout_circuit_ready
    ) else $error("ready stayed high after brown-out disable");

    AST_READY_DELAY: assert property (
        $rose(o_brownout_reset_en) |=> !o_brownout_circuit_ready [*2]
    ) else $error("ready rose without settling");

    AST_RDATA_ONE_CYCLE: assert property (
        !i_rd |=> o_rdata == `BRC_RDATA_IDLE
    ) else $error("read data stood beyond its cycle");

    // configuration pipeline: the second stage only ever copies the first
    AST_SYNC_PIPE: assert property (
        mode_ff == $past(mode_meta_ff)
    ) else $error("mode synchroniser skipped a stage");

    // software mode follows the stored bit level, not only on writes
    AST_SW_LEVEL: assert property (
        mode_ff == `BRC_MODE_SOFTWARE |-> o_brownout_reset_en == sw_brownout_enable_ff
    ) else $error("software mode enable does not follow stored bit");

    // the bit is stored in every mode, even where it has no effect
    AST_SW_STORED: assert property (
        wr_bor |=> sw_brownout_enable_ff == $past(i_wdata[`BRC_SW_EN_BIT])
    ) else $error("software enable write not stored");

    AST_FAST_START_STORED: assert property (
        wr_bor |=> brownout_fast_start_ff == $past(i_wdata[`BRC_FAST_START_BIT])
    ) else $error("fast start write not stored");

    // a cleared fast start must let the band gap go
    AST_FAST_START_IDLE: assert property (
        !brownout_fast_start_ff |-> !o_bandgap_force_on
    ) else $error("band gap forced with fast start clear");

    AST_FAST_START_DEAD_OFF: assert property (
        mode_ff == `BRC_MODE_ALWAYS_OFF |-> !o_bandgap_force_on
    ) else $error("fast start acted in always-off mode");

    AST_FAST_START_READBACK: assert property (
        rd_bor |=> o_rdata[`BRC_FAST_START_BIT] == $past(brownout_fast_start_ff)
    ) else $error("fast start bit does not read back");

    // awake cores never see the low-power regulator state
    AST_LOW_POWER_AWAKE: assert property (
        !i_sleep |-> !o_regulator_low_power
    ) else $error("low-power regulator state while awake");

    AST_LOW_POWER_SLEEP: assert property (
        i_sleep |-> o_regulator_low_power == o_regulator_sleep_power_mode
    ) else $error("low-power regulator state does not follow mode bit in sleep");

    AST_PM_STORED: assert property (
        wr_vreg |=> o_regulator_sleep_power_mode == $past(i_wdata[`BRC_VREG_PM_BIT])
    ) else $error("regulator power mode write not stored");

    // unmapped addresses answer with the idle byte and touch nothing
    AST_UNMAPPED_READ: assert property (
        i_rd && !rd_bor && !rd_vreg |=> o_rdata == `BRC_RDATA_IDLE
    ) else $error("unmapped read returned data");

    AST_UNMAPPED_WRITE: assert property (
        i_wr && !wr_bor && !wr_vreg |=> $stable(sw_brownout_enable_ff) && $stable(brownout_fast_start_ff)
                                        && $stable(regulator_sleep_power_mode_ff)
    ) else $error("unmapped write changed a register");

    // ready can only be high if the circuit was enabled in the cycle before
    AST_READY_NEEDS_EN: assert property (
        o_brownout_circuit_ready |-> $past(o_brownout_reset_en)
    ) else $error("ready high without brown-out enable");

endmodule : brc_ctrl

//--- src/brc_params.svh
// constants for the brown-out and regulator control block
`ifndef BRC_PARAMS_SVH
`define BRC_PARAMS_SVH

// register byte addresses on the plain register port
`define BRC_ADDR_W              8
`define BRC_BOR_CTRL_ADDR       8'h00
`define BRC_VREG_CTRL_ADDR      8'h01
`define BRC_RDATA_IDLE          8'h00

// brownout_control field positions and reset values
`define BRC_SW_EN_BIT           7
`define BRC_FAST_START_BIT      6
`define BRC_READY_BIT           0
`define BRC_SW_EN_RST           1'h1
`define BRC_FAST_START_RST      1'h0

// regulator_control field positions and reset values
`define BRC_VREG_PM_BIT         1
`define BRC_VREG_RSVD_BIT       0
`define BRC_VREG_PM_RST         1'h0
`define BRC_VREG_RSVD_VAL       1'h1

// brownout_mode_cfg encodings
`define BRC_MODE_ALWAYS_ON      2'h3
`define BRC_MODE_OFF_IN_SLEEP   2'h2
`define BRC_MODE_SOFTWARE       2'h1
`define BRC_MODE_ALWAYS_OFF     2'h0
`define BRC_MODE_SYNC_RST       2'h3

// timing: settling time of the brown-out circuit
`define BRC_CLK_PERIOD_NS       4
`define BRC_SETTLE_NS           40
`define BRC_SETTLE_CYCLES       ((`BRC_SETTLE_NS + `BRC_CLK_PERIOD_NS - 1) / `BRC_CLK_PERIOD_NS)

`endif

//--- src/brc_pkg.sv
// types shared by the brown-out and regulator control block
package brc_pkg;

    typedef logic [7:0] brc_byte_t;
    typedef logic [1:0] brc_mode_t;

    // ready-settling state machine
    typedef enum logic [1:0] {
        BRC_ST_OFF,
        BRC_ST_SETTLE,
        BRC_ST_READY
    } brc_settle_state_t;

endpackage : brc_pkg

//--- src/brc_settle.sv
// settling timer that turns the effective brown-out enable into the ready status
`timescale 1ns/1ns
`include "brc_params.svh"

module brc_settle #(
    parameter int SETTLE_CYCLES = `BRC_SETTLE_CYCLES
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_enable,
    output logic      o_ready
);
    import brc_pkg::*;

    localparam int CNT_W = (SETTLE_CYCLES > 1) ? $clog2(SETTLE_CYCLES) : 1;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SETTLE_CYCLES - 1);

    brc_settle_state_t state_ff;
    logic [CNT_W-1:0]  cnt_ff;

    // state: ready falls on the first edge after disable, rises only after the full settle count
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_ff <= BRC_ST_OFF;
        end else begin
            case (state_ff)
                BRC_ST_OFF: begin
                    if (i_enable) begin
                        state_ff <= BRC_ST_SETTLE;
                    end
                end
                BRC_ST_SETTLE: begin
                    if (!i_enable) begin
                        state_ff <= BRC_ST_OFF;
                    end else if (cnt_ff == CNT_LAST) begin
                        state_ff <= BRC_ST_READY;
                    end
                end
                BRC_ST_READY: begin
                    if (!i_enable) begin
                        state_ff <= BRC_ST_OFF;
                    end
                end
                default: begin
                    state_ff <= BRC_ST_OFF;
                end
            endcase
        end
    end

    // settle counter, restarted whenever the circuit is not settling
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_ff <= '0;
        end else if (state_ff == BRC_ST_SETTLE && i_enable) begin
            cnt_ff <= cnt_ff + CNT_W'(1);
        end else begin
            cnt_ff <= '0;
        end
    end

    assign o_ready = (state_ff == BRC_ST_READY);

endmodule : brc_settle

//--- sim/brc_ctrl_tb_top.sv
// self-checking bench for the brown-out and regulator control registers
`timescale 1ns/1ns
`include "brc_params.svh"

module brc_ctrl_tb_top;
    import brc_pkg::*;

    localparam int SETTLE = 2;

    logic                    i_clk;
    logic                    i_rst;
    logic [`BRC_ADDR_W-1:0]  i_addr;
    brc_byte_t               i_wdata;
    logic                    i_wr;
    logic                    i_rd;
    brc_byte_t               o_rdata;
    brc_mode_t               i_brownout_mode_cfg;
    logic                    i_sleep;
    logic                    o_brownout_reset_en;
    logic                    o_bandgap_force_on;
    logic                    o_regulator_sleep_power_mode;
    logic                    o_regulator_low_power;
    logic                    o_brownout_circuit_ready;
    int                      error_cnt;
    int                      cmp_count;
    int                      seed;
    logic                    rd_seen;
    brc_byte_t               exp_q[$];
    brc_byte_t               exp_b;
    logic                    exp_en;
    logic                    sw;
    logic                    fs;
    logic                    slp;
    logic                    pm;

    brc_ctrl #(.SETTLE_CYCLES(SETTLE)) brc_ctrl_inst (
        .i_clk                        (i_clk),
        .i_rst                        (i_rst),
        .i_addr                       (i_addr),
        .i_wdata                      (i_wdata),
        .i_wr                         (i_wr),
        .i_rd                         (i_rd),
        .o_rdata                      (o_rdata),
        .i_brownout_mode_cfg          (i_brownout_mode_cfg),
        .i_sleep                      (i_sleep),
        .o_brownout_reset_en          (o_brownout_reset_en),
        .o_bandgap_force_on           (o_bandgap_force_on),
        .o_regulator_sleep_power_mode (o_regulator_sleep_power_mode),
        .o_regulator_low_power        (o_regulator_low_power),
        .o_brownout_circuit_ready     (o_brownout_circuit_ready)
    );

    // 4 ns clock
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    task automatic stop_test();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk_byte(input brc_byte_t e, input brc_byte_t g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("Error t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("Error t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk_bit

    // one-cycle strobes; the leading edge wait keeps raise and lower in separate steps
    task automatic wr(input logic [7:0] a, input brc_byte_t d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input brc_byte_t e);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        exp_q.push_back(e);
        @(posedge i_clk);
        i_rd   <= 1'b0;
    endtask : rd

    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : step

    // read data stand only in the cycle after the strobe, idle zero otherwise
    always @(posedge i_clk) rd_seen <= i_rd;
    always @(negedge i_clk) begin
        if (rd_seen) begin
            if (exp_q.size() == 0) begin
                chk_byte(8'h00, 8'hff);
            end else begin
                chk_byte(exp_q.pop_front(), o_rdata);
            end
        end else begin
            chk_byte(`BRC_RDATA_IDLE, o_rdata);
        end
    end

    // hang guard: a run that overstays counts as a mismatch
    initial begin
        repeat (100000) @(posedge i_clk);
        error_cnt++;
        stop_test();
    end

    initial begin
        error_cnt = 0;
        cmp_count = 0;
        seed = 17;
        rd_seen = 1'b0;
        i_rst = 1'b1;
        i_addr = 8'h00;
        i_wdata = 8'h00;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_brownout_mode_cfg = 2'h3;
        i_sleep = 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        // reset values: enable on, fast start off, regulator normal
        step(8);
        rd(`BRC_BOR_CTRL_ADDR, 8'h81);
        rd(`BRC_VREG_CTRL_ADDR, 8'h01);
        // every mode against every enable, fast start and sleep state
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 8; k++) begin
                sw = k[2];
                fs = k[1];
                slp = k[0];
                i_brownout_mode_cfg <= m[1:0];
                i_sleep <= slp;
                wr(`BRC_BOR_CTRL_ADDR, {sw, fs, 6'($random(seed))});
                step(8);
                exp_en = (m == 3) ? 1'b1 : (m == 0) ? 1'b0 : (m == 2) ? !slp : sw;
                chk_bit(exp_en, o_brownout_reset_en);
                chk_bit(fs & (m == 1 || m == 2), o_bandgap_force_on);
                chk_bit(exp_en, o_brownout_circuit_ready);
                rd(`BRC_BOR_CTRL_ADDR, {sw, fs, 5'h00, exp_en});
            end
        end
        // ready settling: low through the count, high right after it, drops one cycle after disable
        i_brownout_mode_cfg <= 2'h1;
        wr(`BRC_BOR_CTRL_ADDR, 8'h00);
        step(6);
        chk_bit(1'b0, o_brownout_circuit_ready);
        wr(`BRC_BOR_CTRL_ADDR, 8'h80);
        #1;
        chk_bit(1'b1, o_brownout_reset_en);
        step(SETTLE);
        chk_bit(1'b0, o_brownout_circuit_ready);
        step(1);
        chk_bit(1'b1, o_brownout_circuit_ready);
        wr(`BRC_BOR_CTRL_ADDR, 8'h40);
        step(1);
        chk_bit(1'b0, o_brownout_circuit_ready);
        // regulator power mode with and without sleep
        for (int k = 0; k < 4; k++) begin
            pm = k[0];
            slp = k[1];
            i_sleep <= slp;
            wr(`BRC_VREG_CTRL_ADDR, {6'($random(seed)), pm, 1'b1});
            step(1);
            chk_bit(pm, o_regulator_sleep_power_mode);
            chk_bit(pm & slp, o_regulator_low_power);
            rd(`BRC_VREG_CTRL_ADDR, {6'h00, pm, 1'b1});
        end
        // unmapped address: write dropped, read zero, each access one idle cycle apart
        wr(8'h05, 8'hff);
        rd(8'h05, 8'h00);
        rd(`BRC_BOR_CTRL_ADDR, 8'h40);
        // second reset mid-run returns to always-on
        step(2);
        i_rst <= 1'b1;
        step(2);
        chk_bit(1'b1, o_brownout_reset_en);
        chk_bit(1'b0, o_regulator_sleep_power_mode);
        i_rst <= 1'b0;
        i_brownout_mode_cfg <= 2'h3;
        step(8);
        rd(`BRC_BOR_CTRL_ADDR, 8'h81);
        step(4);
        if (exp_q.size() != 0) begin
            error_cnt++;
        end
        stop_test();
    end

endmodule : brc_ctrl_tb_top
